// >>> shared/wd_map.svh
// Register offsets, field positions, reset values and timing counts of the watchdog block.
// Functional notes
// - Watchdog reset pulse lasts one system clock.
// - Startup delay starts when reset pulse falls.
// - Watchdog flag set by watchdog reset, cleared.
// - Brown-out flag set by brown-out reset.
// - Pin flag set by external pin reset.
// - Power-on flag cleared only by software zero.
// - Pin disable bit one stops pin reset.
// - Counter advances only on oscillator edges.
// - Time-out gives interrupt or reset per mode.
// - Restart strobe clears counter to zero.
// - Interrupt mode raises only the interrupt.
// - Reset mode resets without any interrupt.
// - Combined mode: interrupt first, then reset.
// - Fuse forces reset mode, enables locked.
// - Reset clear, prescaler change need sequence.
// - Timed write accepted only inside window.
// - Time-out selectable about 1 ms to 8 s.
// - Watchdog flag forces reset enable high.
// - Change enable self-clears after four cycles.
// - Prescaler codes map to oscillator cycle counts.
// - Vector clears flag; clears interrupt enable only while reset enable is set.
`ifndef WD_MAP_SVH
`define WD_MAP_SVH
`define ADDR_RESET_CAUSE 2'h0
`define ADDR_SYSTEM_CONTROL 2'h1
`define ADDR_WD_CONTROL 2'h2
`define BIT_WD_FLAG 3
`define BIT_BOR_FLAG 2
`define BIT_PIN_FLAG 1
`define BIT_POR_FLAG 0
`define BIT_RESET_PIN_DISABLE 3
`define SYSCTL_RESET 5'h00
`define SYSCTL_WIDTH 5
`define WD_BASE_CYCLES 21'h000800
`define WD_SHORT_CYCLES 21'h000400
`define WD_CODE_LONG_MAX 4'h9
`define WD_CODE_SHORT_MIN 4'ha
`define WD_CODE_SHORT_MAX 4'hd
`define WD_PRESC_RESET 4'h0
`define CHANGE_WINDOW_CYCLES 3'h4
`define REF_CLK_MHZ 200
`define STARTUP_DELAY_US 64
`endif

// >>> shared/wd_pkg.sv
// Types shared by the watchdog block.
`default_nettype none
package wd_pkg;
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
	typedef struct packed {
		logic irq_flag;
		logic irq_enable;
		logic presc_hi;
		logic change_enable;
		logic reset_enable;
		logic [2:0] presc_lo;
	} wd_ctrl_type;
	typedef enum logic [1:0] {
		MODE_STOPPED = 2'b00,
		MODE_IRQ = 2'b01,
		MODE_COMBINED = 2'b11,
		MODE_RESET = 2'b10
	} wd_mode_type;
endpackage
`default_nettype wire

// >>> src/watchdog_with_reset_flags.sv
// Watchdog timer with reset-cause flags, reset-pin disable and startup delay.
`include "wd_map.svh"
`default_nettype none
module watchdog_with_reset_flags #(
	parameter logic [23:0] STARTUP_CYCLES = 24'(`STARTUP_DELAY_US * `REF_CLK_MHZ)
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire wd_pkg::reg_req_type bus,
	output logic [7:0] rd_data,
	input wire logic wd_osc_clk,
	input wire logic brownout_reset,
	input wire logic pin_reset_n,
	input wire logic watchdog_always_on_fuse,
	input wire logic restart_strobe,
	input wire logic irq_vector_ack,
	output logic wd_reset_pulse,
	output logic system_reset_hold,
	output logic wd_irq,
	output logic reset_pin_enabled
);
	import wd_pkg::*;

	function automatic logic [20:0] timeout_cycles(input logic [3:0] code);
		if (code <= `WD_CODE_LONG_MAX) begin
			return `WD_BASE_CYCLES << code;
		end else if (code <= `WD_CODE_SHORT_MAX) begin
			return `WD_SHORT_CYCLES >> (code - `WD_CODE_SHORT_MIN);
		end else begin
			return `WD_BASE_CYCLES;
		end
	endfunction

	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction

	function automatic wd_mode_type mode_of(input logic fuse, input logic wd_reset_enable, input logic wd_irq_enable);
		if (fuse) begin
			return MODE_RESET;
		end else begin
			return wd_mode_type'({wd_reset_enable, wd_irq_enable});
		end
	endfunction

	// Pin-level inputs are synchronised; the watchdog oscillator is sampled, not used as a clock,
	// so the 200 MHz clock easily resolves every 128 kHz edge.
	logic [2:0] osc_sync;
	logic [1:0] bor_sync;
	logic [1:0] pin_sync;
	logic [1:0] fuse_sync;
	logic osc_edge;
	logic fuse_on;
	logic pin_reset_event;
	logic reset_source;
	logic [23:0] delay_count;
	logic [20:0] wd_count;
	logic [3:0] presc;
	logic wde_reg;
	logic wd_irq_enable;
	logic irq_flag;
	logic [2:0] win_count;
	logic window_open;
	logic wde_eff;
	logic wd_irq_enable_eff;
	wd_mode_type mode;
	logic expire;
	logic wd_reset_req;
	logic set_irq;
	logic wd_flag;
	logic bor_flag;
	logic pin_flag;
	logic por_flag;
	logic [`SYSCTL_WIDTH-1:0] sysctl;
	logic reset_pin_disable;
	logic wr_status;
	logic wr_sysctl;
	logic wr_ctrl;
	wd_ctrl_type wr_data;
	logic open_req;
	logic timed_wr;
	logic clear_all;
	logic [7:0] next_rd_data;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			osc_sync <= 3'h0;
			bor_sync <= 2'h0;
			pin_sync <= 2'h3;
			fuse_sync <= 2'h0;
		end else begin
			osc_sync <= {osc_sync[1:0], wd_osc_clk};
			bor_sync <= {bor_sync[0], brownout_reset};
			pin_sync <= {pin_sync[0], pin_reset_n};
			fuse_sync <= {fuse_sync[0], watchdog_always_on_fuse};
		end
	end

	assign osc_edge = osc_sync[1] & ~osc_sync[2];
	assign fuse_on = fuse_sync[1];
	assign reset_pin_disable = sysctl[`BIT_RESET_PIN_DISABLE];
	assign reset_pin_enabled = ~reset_pin_disable;
	assign pin_reset_event = ~pin_sync[1] & ~reset_pin_disable;
	assign reset_source = wd_reset_pulse | bor_sync[1] | pin_reset_event;

	// The delay reloads while any source is active, so it runs out only after the last one
	// falls; for the one-cycle watchdog pulse it starts on the pulse's falling edge.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			delay_count <= STARTUP_CYCLES;
		end else if (reset_source) begin
			delay_count <= STARTUP_CYCLES;
		end else if (delay_count != 24'h0) begin
			delay_count <= delay_count - 24'h1;
		end
	end

	assign system_reset_hold = reset_source | (delay_count != 24'h0);
	assign clear_all = rst | system_reset_hold;

	assign wr_status = bus.wr & (bus.addr == `ADDR_RESET_CAUSE);
	assign wr_sysctl = bus.wr & (bus.addr == `ADDR_SYSTEM_CONTROL);
	assign wr_ctrl = bus.wr & (bus.addr == `ADDR_WD_CONTROL);
	assign wr_data = bus.wdata;

	// Reset-cause flags survive internal resets; only the power-on reset or a software zero clears the three
	// event flags, and the power-on reset sets its own flag.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			por_flag <= 1'b1;
			bor_flag <= 1'b0;
			pin_flag <= 1'b0;
			wd_flag <= 1'b0;
		end else begin
			wd_flag <= sticky(wd_flag, wd_reset_pulse,
				wr_status & ~bus.wdata[`BIT_WD_FLAG]);
			bor_flag <= sticky(bor_flag, bor_sync[1],
				wr_status & ~bus.wdata[`BIT_BOR_FLAG]);
			pin_flag <= sticky(pin_flag, pin_reset_event,
				wr_status & ~bus.wdata[`BIT_PIN_FLAG]);
			por_flag <= sticky(por_flag, 1'b0,
				wr_status & ~bus.wdata[`BIT_POR_FLAG]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (clear_all) begin
			sysctl <= `SYSCTL_RESET;
		end else if (wr_sysctl) begin
			sysctl <= bus.wdata[`SYSCTL_WIDTH-1:0];
		end
	end

	assign wde_eff = wde_reg | wd_flag | fuse_on;
	assign wd_irq_enable_eff = wd_irq_enable & ~fuse_on;
	assign mode = mode_of(fuse_on, wde_eff, wd_irq_enable_eff);
	assign window_open = win_count != 3'h0;
	assign open_req = wr_ctrl & wr_data.change_enable & wr_data.reset_enable;
	assign timed_wr = wr_ctrl & window_open & ~wr_data.change_enable;

	always_ff @(posedge ref_clk) begin
		if (clear_all) begin
			win_count <= 3'h0;
		end else if (open_req) begin
			win_count <= `CHANGE_WINDOW_CYCLES;
		end else if (timed_wr) begin
			win_count <= 3'h0;
		end else if (window_open) begin
			win_count <= win_count - 3'h1;
		end
	end

	// Outside the window software may only raise the reset enable.
	always_ff @(posedge ref_clk) begin
		if (clear_all) begin
			wde_reg <= 1'b0;
		end else if (timed_wr) begin
			wde_reg <= wr_data.reset_enable;
		end else if (wr_ctrl & wr_data.reset_enable) begin
			wde_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (clear_all) begin
			presc <= `WD_PRESC_RESET;
		end else if (timed_wr) begin
			presc <= {wr_data.presc_hi, wr_data.presc_lo};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (clear_all) begin
			wd_irq_enable <= 1'b0;
		end else if (irq_vector_ack & wde_eff) begin
			wd_irq_enable <= 1'b0;
		end else if (wr_ctrl) begin
			wd_irq_enable <= wr_data.irq_enable;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (clear_all) begin
			irq_flag <= 1'b0;
		end else begin
			irq_flag <= sticky(irq_flag, set_irq,
				irq_vector_ack | (wr_ctrl & wr_data.irq_flag));
		end
	end

	// Compare with greater-or-equal so that shortening the period below the running count
	// expires on the next oscillator edge instead of wrapping the whole 21-bit counter.
	assign expire = (mode != MODE_STOPPED) & osc_edge &
		(wd_count >= timeout_cycles(presc) - 21'h1);

	// A pending flag in combined mode means the handler never ran: the next expiry resets.
	assign wd_reset_req = expire & ((mode == MODE_RESET) |
		((mode == MODE_COMBINED) & irq_flag));
	assign set_irq = expire & ((mode == MODE_IRQ) |
		((mode == MODE_COMBINED) & ~irq_flag));

	always_ff @(posedge ref_clk) begin
		if (clear_all | restart_strobe | (mode == MODE_STOPPED)) begin
			wd_count <= 21'h0;
		end else if (osc_edge) begin
			wd_count <= expire ? 21'h0 : wd_count + 21'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wd_reset_pulse <= 1'b0;
		end else begin
			wd_reset_pulse <= wd_reset_req;
		end
	end

	// Level request so it can wake the core from sleep.
	assign wd_irq = irq_flag & wd_irq_enable_eff;

	always_comb begin
		next_rd_data = 8'h00;
		if (!bus.rd) begin
			next_rd_data = 8'h00;
		end else if (bus.addr == `ADDR_RESET_CAUSE) begin
			next_rd_data = {4'h0, wd_flag, bor_flag, pin_flag, por_flag};
		end else if (bus.addr == `ADDR_SYSTEM_CONTROL) begin
			next_rd_data = {3'h0, sysctl};
		end else if (bus.addr == `ADDR_WD_CONTROL) begin
			next_rd_data = {irq_flag, wd_irq_enable_eff, presc[3], window_open, wde_eff, presc[2:0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_pulse_one_cycle: assert property (wd_reset_pulse |=> !wd_reset_pulse)
		else $error("watchdog reset pulse longer than one cycle");
	a_delay_after_pulse: assert property (wd_reset_pulse ##1 !reset_source |=>
		delay_count == STARTUP_CYCLES - 24'h1)
		else $error("startup delay did not start at pulse fall");
	a_wd_flag_set: assert property (wd_reset_pulse |=> wd_flag)
		else $error("watchdog flag not set by watchdog reset");
	a_bor_flag_set: assert property (bor_sync[1] |=> bor_flag)
		else $error("brown-out flag not set");
	a_pin_flag_set: assert property (pin_reset_event |=> pin_flag)
		else $error("pin flag not set");
	a_por_flag_kept: assert property (por_flag && !wr_status |=> por_flag)
		else $error("power-on flag lost without software write");
	a_pin_disabled: assert property (reset_pin_disable && !pin_flag |=> !pin_flag)
		else $error("pin reset acted while disabled");
	a_osc_advance: assert property (!clear_all && !restart_strobe && mode != MODE_STOPPED &&
		!osc_edge |=> $stable(wd_count))
		else $error("counter moved without an oscillator edge");
	a_restart_zero: assert property (restart_strobe |=> wd_count == 21'h0)
		else $error("restart did not clear counter");
	a_irq_mode_only: assert property (expire && mode == MODE_IRQ |=>
		irq_flag && !wd_reset_pulse)
		else $error("interrupt mode expiry misbehaved");
	a_reset_mode_only: assert property (expire && mode == MODE_RESET |=>
		wd_reset_pulse && !$rose(irq_flag))
		else $error("reset mode expiry misbehaved");
	a_combined_first: assert property (expire && mode == MODE_COMBINED && !irq_flag |=>
		irq_flag && !wd_reset_pulse)
		else $error("combined mode first expiry misbehaved");
	a_fuse_lock: assert property (fuse_on && bus.rd && bus.addr == `ADDR_WD_CONTROL |=>
		rd_data[3] && !rd_data[6])
		else $error("fuse did not lock enables");
	a_presc_guard: assert property (!window_open && !clear_all |=> $stable(presc))
		else $error("prescaler changed outside window");
	a_window_opens: assert property (open_req && !clear_all |=> window_open)
		else $error("change window did not open");
	a_window_closes: assert property (open_req ##1
		(!open_req && !timed_wr && !clear_all) [*4] |=> !window_open)
		else $error("change window stayed open past four cycles");
	a_count_step: assert property (!clear_all && !restart_strobe && mode != MODE_STOPPED &&
		osc_edge && !expire |=> wd_count == $past(wd_count) + 21'h1)
		else $error("counter did not advance by one on an oscillator edge");
	a_flag_forces_wde: assert property (wd_flag && bus.rd &&
		bus.addr == `ADDR_WD_CONTROL |=> rd_data[3])
		else $error("watchdog flag did not force reset enable");
	a_vector_clear: assert property (irq_vector_ack && wde_eff && !set_irq && !clear_all |=>
		!irq_flag && !wd_irq_enable)
		else $error("vector did not return to reset mode");

	c_reset_pulse: cover property (wd_reset_pulse);
	c_irq_raised: cover property (set_irq);
	c_timed_write: cover property (open_req ##[1:4] timed_wr);
	c_combined_reset: cover property (set_irq ##[1:1000] wd_reset_pulse);
endmodule // watchdog_with_reset_flags
`default_nettype wire

// >>> test/osc_source.sv
// Free-running stand-in for the watchdog's own on-chip oscillator.
`default_nettype none
module osc_source #(
	parameter int HALF_NS = 15
) (
	output logic osc_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sped up from the real rate so that even the 2048-cycle time-out fits a short run.
	// Its period is exactly six system clocks, with edges midway between system clock edges.
	initial begin
		osc_clk = 1'b0;
		forever #(HALF_NS) osc_clk = ~osc_clk;
	end
endmodule // osc_source
`default_nettype wire

// >>> test/watchdog_with_reset_flags_bench.sv
// Self-checking bench for the watchdog with reset-cause flags.
`default_nettype none
module watchdog_with_reset_flags_bench
	import wd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	reg_req_type bus = '0;
	logic [7:0] rd_data;
	logic osc;
	logic bor = 1'b0;
	logic pin_n = 1'b1;
	logic fuse = 1'b0;
	logic rs = 1'b0;
	logic ack = 1'b0;
	logic wd_reset_pulse;
	logic hold;
	logic irq;
	logic pin_en;
	int err_count = 0;
	int checks = 0;
	int pulses = 0;
	int n;
	int t;
	int p0;
	int seed = 32'h681b4b81;
	logic [7:0] v;

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (wd_reset_pulse === 1'b1) pulses++;

	osc_source #(.HALF_NS(15)) u_osc (.osc_clk(osc));
	watchdog_with_reset_flags #(.STARTUP_CYCLES(24'd16)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data), .wd_osc_clk(osc),
		.brownout_reset(bor), .pin_reset_n(pin_n), .watchdog_always_on_fuse(fuse),
		.restart_strobe(rs), .irq_vector_ack(ack), .wd_reset_pulse(wd_reset_pulse),
		.system_reset_hold(hold), .wd_irq(irq), .reset_pin_enabled(pin_en)
	);

	// Time-out length in oscillator cycles for a prescaler code.
	function automatic int to_osc(input logic [3:0] c);
		if (c <= 4'h9) return 2048 << c;
		if (c <= 4'hd) return 1024 >> (c - 4'ha);
		return 2048;
	endfunction
	// Control value for interrupt mode with a given prescaler code.
	function automatic logic [7:0] ctl(input logic [3:0] c);
		return {2'b01, c[3], 2'b00, c[2:0]};
	endfunction
	function automatic bit hit(input int s);
		return s == 0 ? irq === 1'b1 : s == 1 ? wd_reset_pulse === 1'b1 : hold === 1'b0;
	endfunction

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e, input string s);
		@(posedge ref_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		#1 chk(s, e, rd_data);
	endtask
	task automatic strobe(input bit vec);
		@(posedge ref_clk);
		if (vec) begin
			ack <= 1'b1;
		end else begin
			rs <= 1'b1;
		end
		@(posedge ref_clk);
		ack <= 1'b0;
		rs <= 1'b0;
	endtask
	// A wait that runs out ends the run as a mismatch.
	task automatic wt(input int s, input int lim);
		n = 0;
		while (n < lim && !hit(s)) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n >= lim) begin
			chk("wait bound", 8'h00, 8'h01);
			end_of_test();
		end
	endtask
	task automatic hold_pin(input logic [3:0] k);
		@(posedge ref_clk);
		pin_n <= 1'b0;
		repeat (k) @(posedge ref_clk);
		pin_n <= 1'b1;
	endtask

	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		wt(2, 100);
		chk("startup hold", 8'h01, 8'(n >= 16));
		rd(`ADDR_RESET_CAUSE, 8'h01, "cause");
		rd(`ADDR_SYSTEM_CONTROL, 8'(`SYSCTL_RESET), "sysctl");
		rd(`ADDR_WD_CONTROL, 8'h00, "ctrl");
		wr(2'h3, 8'hff);
		rd(2'h3, 8'h00, "unmapped");
		wr(`ADDR_RESET_CAUSE, 8'h0e);
		rd(`ADDR_RESET_CAUSE, 8'h00, "cause");
		repeat (4) begin
			v = 8'($random(seed));
			wr(`ADDR_SYSTEM_CONTROL, v);
			rd(`ADDR_SYSTEM_CONTROL, v & 8'h1f, "sysctl");
			chk("pin enable", {7'h0, ~v[3]}, {7'h0, pin_en});
		end
		wr(`ADDR_SYSTEM_CONTROL, 8'h00);
		wr(`ADDR_WD_CONTROL, 8'h0d);
		rd(`ADDR_WD_CONTROL, 8'h08, "ctrl");
		wr(`ADDR_WD_CONTROL, 8'h00);
		rd(`ADDR_WD_CONTROL, 8'h08, "ctrl");
		wr(`ADDR_WD_CONTROL, 8'h58);
		rd(`ADDR_WD_CONTROL, 8'h58, "window open");
		repeat (4) @(posedge ref_clk);
		rd(`ADDR_WD_CONTROL, 8'h48, "window shut");
		wr(`ADDR_WD_CONTROL, 8'h65);
		rd(`ADDR_WD_CONTROL, 8'h48, "late write");
		p0 = pulses;
		// Every code is written through the window; the short ones and code 0 are timed.
		for (int c = 0; c < 16; c++) begin
			wr(`ADDR_WD_CONTROL, 8'hd8);
			wr(`ADDR_WD_CONTROL, ctl(4'(c)));
			rd(`ADDR_WD_CONTROL, ctl(4'(c)), "prescaler");
			if (c == 0 || (c >= 10 && c <= 13)) begin
				t = 6 * to_osc(4'(c));
				strobe(1'b0);
				wr(`ADDR_WD_CONTROL, ctl(4'(c)) | 8'h80);
				wt(0, 20000);
				chk("expiry time", 8'h01, 8'(n > t - 16 && n < t + 16));
			end
		end
		chk("no reset in irq mode", 8'(p0), 8'(pulses));
		// The shortest period is set through the window so that skipped restarts would show.
		wr(`ADDR_WD_CONTROL, 8'hd8);
		wr(`ADDR_WD_CONTROL, ctl(4'hd) | 8'h80);
		#1 chk("irq cleared", 8'h00, {7'h0, irq});
		repeat (6) begin
			repeat (400) @(posedge ref_clk);
			strobe(1'b0);
		end
		chk("restart holds off", 8'h00, {7'h0, irq});
		strobe(1'b0);
		wr(`ADDR_WD_CONTROL, 8'hed);
		wt(0, 2000);
		chk("first expiry no reset", 8'(p0), 8'(pulses));
		strobe(1'b1);
		#1 chk("vector clears irq", 8'h00, {7'h0, irq});
		rd(`ADDR_WD_CONTROL, 8'h2d, "after vector");
		wt(1, 2000);
		@(posedge ref_clk);
		#1 chk("pulse width", 8'h00, {7'h0, wd_reset_pulse});
		chk("hold on pulse", 8'h01, {7'h0, hold});
		wt(2, 200);
		chk("hold after pulse", 8'h01, 8'(n >= 15));
		rd(`ADDR_RESET_CAUSE, 8'h08, "cause");
		rd(`ADDR_WD_CONTROL, 8'h08, "forced enable");
		wr(`ADDR_WD_CONTROL, 8'h18);
		wr(`ADDR_WD_CONTROL, 8'h00);
		rd(`ADDR_WD_CONTROL, 8'h08, "forced enable");
		wr(`ADDR_RESET_CAUSE, 8'h00);
		rd(`ADDR_RESET_CAUSE, 8'h00, "cause");
		wr(`ADDR_WD_CONTROL, 8'h18);
		wr(`ADDR_WD_CONTROL, 8'h00);
		rd(`ADDR_WD_CONTROL, 8'h00, "wd off");
		@(posedge ref_clk);
		bor <= 1'b1;
		repeat (4) @(posedge ref_clk);
		bor <= 1'b0;
		wt(2, 300);
		rd(`ADDR_RESET_CAUSE, 8'h04, "cause");
		wr(`ADDR_SYSTEM_CONTROL, 8'h08);
		hold_pin(4'h6);
		repeat (3) @(posedge ref_clk);
		chk("pin ignored", 8'h00, {7'h0, hold});
		rd(`ADDR_RESET_CAUSE, 8'h04, "cause");
		wr(`ADDR_SYSTEM_CONTROL, 8'h00);
		hold_pin(4'h6);
		wt(2, 300);
		rd(`ADDR_RESET_CAUSE, 8'h06, "cause");
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		wt(2, 100);
		rd(`ADDR_RESET_CAUSE, 8'h01, "cause");
		@(posedge ref_clk);
		fuse <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(`ADDR_WD_CONTROL, 8'h08, "fuse lock");
		wr(`ADDR_WD_CONTROL, 8'h58);
		wr(`ADDR_WD_CONTROL, 8'h40);
		rd(`ADDR_WD_CONTROL, 8'h08, "fuse lock");
		end_of_test();
	end
endmodule // watchdog_with_reset_flags_bench
`default_nettype wire
